// *** pfm_top.sv ***
// pin function multiplexer for port e, port d upper data and fifo interface pins
`timescale 1ns/1ps
`default_nettype none
module pfm_top
    import pfm_pkg::*;
(
    input  wire logic             aclk,
    input  wire logic             aresetn,
    input  wire logic [31:0]      s_axi_awaddr,
    input  wire logic             s_axi_awvalid,
    output logic                  s_axi_awready,
    input  wire logic [31:0]      s_axi_wdata,
    input  wire logic [3:0]       s_axi_wstrb,
    input  wire logic             s_axi_wvalid,
    output logic                  s_axi_wready,
    output logic [1:0]            s_axi_bresp,
    output logic                  s_axi_bvalid,
    input  wire logic             s_axi_bready,
    input  wire logic [31:0]      s_axi_araddr,
    input  wire logic             s_axi_arvalid,
    output logic                  s_axi_arready,
    output logic [31:0]           s_axi_rdata,
    output logic [1:0]            s_axi_rresp,
    output logic                  s_axi_rvalid,
    input  wire logic             s_axi_rready,
    input  wire logic [7:0]       port_e_pin_i,
    output logic [7:0]            port_e_pin_o,
    output logic [7:0]            port_e_pin_oe,
    input  wire logic [7:0]       port_d_pin_i,
    output logic [7:0]            port_d_pin_o,
    output logic [7:0]            port_d_pin_oe,
    input  wire logic [5:0]       wave_ready_pin,
    output logic [5:0]            wave_control_pin_o,
    output logic [5:0]            wave_control_pin_oe,
    input  wire logic             interface_clock_i,
    output logic                  interface_clock_o,
    output logic                  interface_clock_oe,
    input  wire logic [1:0]       fifo_address_pins,
    input  wire logic             irq4_input,
    input  wire logic             irq5_input_n,
    input  wire logic             timer1_count_pin,
    input  wire logic             timer0_overflow,
    input  wire logic             timer1_overflow,
    input  wire logic             timer2_overflow,
    input  wire logic [1:0]       serial0_mode,
    input  wire logic             serial0_data,
    input  wire logic [1:0]       serial1_mode,
    input  wire logic             serial1_data,
    input  wire logic             wave_address_bit8,
    input  wire logic [5:0]       wave_control_out,
    input  wire pfm_flags_s       fifo_flags,
    input  wire logic [7:0]       fifo_data_hi_o,
    input  wire logic             fifo_data_hi_oe,
    output logic [7:0]            fifo_data_hi_i,
    output logic [5:0]            wave_ready_in,
    output logic                  slave_read_strobe,
    output logic                  slave_write_strobe,
    output logic                  interface_clock_edge,
    output logic                  irq4_req,
    output logic                  irq5_req,
    output logic                  irq6_req,
    output logic                  timer2_reload,
    output logic                  timer1_count
);
    localparam int SW = 28;
    localparam logic [7:0] ALL1 = 8'hFF;

    // software registers
    logic [7:0]  port_e_alt_select_q;
    logic [7:0]  interface_config_q;
    logic [7:0]  fifo_pin_polarity_q;
    logic [7:0]  misc_ctrl_q;
    logic [7:0]  pe_out_q;
    logic [7:0]  pe_oe_q;
    logic [7:0]  pd_out_q;
    logic [7:0]  pd_oe_q;

    // synchroniser stages for every pin input
    logic [SW-1:0] meta_q;
    logic [SW-1:0] sync_q;
    logic [SW-1:0] prev_q;
    logic [SW-1:0] raw_pins;

    logic [7:0]  pe_s;
    logic [7:0]  pd_s;
    logic [5:0]  rdy_s;
    logic        irq4_s;
    logic        irq5_s;
    logic        t1_s;
    logic        interface_clock_s;
    logic [1:0]  fadr_s;
    logic        mode_slave;
    logic        mode_wave;
    logic        wide_bus;
    logic        interface_clock_eff;
    logic        interface_clock_prev_q;
    logic [PFM_ACC_BITS-1:0] acc_q;
    logic                    interface_clock_int_q;
    logic [PFM_ACC_BITS:0]   acc_sum;
    pfm_mode_e               mode;

    // decode of a word address to a register index, index PFM_NREG if unmapped
    function automatic logic [3:0] reg_index(input logic [31:0] addr);
        logic [3:0] idx;
        idx = 4'(PFM_NREG);
        if (addr[31:8] == 24'h00_0000 && addr[1:0] == 2'b00 &&
            addr[7:2] < 6'(PFM_NREG)) begin
            idx = addr[5:2];
        end
        return idx;
    endfunction

    assign raw_pins = {port_d_pin_i, fifo_address_pins, interface_clock_i, timer1_count_pin,
                       irq5_input_n, irq4_input, wave_ready_pin, port_e_pin_i};
    assign pe_s    = sync_q[7:0];
    assign rdy_s   = sync_q[13:8];
    assign irq4_s  = sync_q[14];
    assign irq5_s  = sync_q[15];
    assign t1_s    = sync_q[16];
    assign interface_clock_s = sync_q[17];
    assign fadr_s  = sync_q[19:18];
    assign pd_s    = sync_q[27:20];
    assign mode       = pfm_mode_e'(interface_config_q[1:0]);
    assign mode_slave = (mode == PFM_MODE_SLAVE);
    assign mode_wave  = (mode == PFM_MODE_WAVE);
    assign wide_bus   = (mode_slave || mode_wave) && misc_ctrl_q[PFM_MISC_WORDWIDE];

    // two-stage synchroniser, third stage for edge detection
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            meta_q <= '0;
            sync_q <= '0;
            prev_q <= '0;
        end else begin
            meta_q <= raw_pins;
            sync_q <= meta_q;
            prev_q <= sync_q;
        end
    end

    // edge events toward the cpu core
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            irq4_req      <= 1'b0;
            irq5_req      <= 1'b0;
            irq6_req      <= 1'b0;
            timer2_reload <= 1'b0;
            timer1_count  <= 1'b0;
        end else begin
            irq4_req <= irq4_s && !prev_q[14];
            irq5_req <= !irq5_s && prev_q[15];
            irq6_req <= port_e_alt_select_q[PFM_PE_IRQ6] &&
                        pe_s[PFM_PE_IRQ6] && !prev_q[PFM_PE_IRQ6];
            timer2_reload <= port_e_alt_select_q[PFM_PE_TIMER2_RELOAD_INPUT] && misc_ctrl_q[PFM_MISC_T2_EXT] &&
                             !pe_s[PFM_PE_TIMER2_RELOAD_INPUT] && prev_q[PFM_PE_TIMER2_RELOAD_INPUT];
            timer1_count <= misc_ctrl_q[PFM_MISC_T1_SEL] && !t1_s && prev_q[16];
        end
    end

    // internal interface clock by phase accumulator
    assign acc_sum = {1'b0, acc_q} + (interface_config_q[PFM_IFC_RATE48] ?
                     (PFM_ACC_BITS+1)'(PFM_STEP_FAST) : (PFM_ACC_BITS+1)'(PFM_STEP_SLOW));
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            acc_q       <= '0;
            interface_clock_int_q <= 1'b0;
        end else if (interface_config_q[PFM_IFC_INTERNAL]) begin
            acc_q <= acc_sum[PFM_ACC_BITS-1:0];
            if (acc_sum[PFM_ACC_BITS]) begin
                interface_clock_int_q <= !interface_clock_int_q;
            end
        end
    end

    // effective interface clock and its rising edge
    assign interface_clock_eff = (interface_config_q[PFM_IFC_INTERNAL] ? interface_clock_int_q : interface_clock_s) ^
                       interface_config_q[PFM_IFC_INVERT];
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            interface_clock_prev_q         <= 1'b0;
            interface_clock_edge <= 1'b0;
            interface_clock_o    <= 1'b0;
            interface_clock_oe   <= 1'b0;
        end else begin
            interface_clock_prev_q         <= interface_clock_eff;
            interface_clock_edge <= interface_clock_eff && !interface_clock_prev_q;
            interface_clock_o    <= interface_clock_int_q ^ interface_config_q[PFM_IFC_INVERT];
            interface_clock_oe   <= interface_config_q[PFM_IFC_INTERNAL] &&
                                    interface_config_q[PFM_IFC_CLK_OE];
        end
    end

    // fifo interface sampled on interface clock edges
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            slave_read_strobe   <= 1'b0;
            slave_write_strobe  <= 1'b0;
            wave_ready_in       <= '0;
            wave_control_pin_o  <= '0;
            wave_control_pin_oe <= '0;
            fifo_data_hi_i      <= '0;
        end else if (interface_clock_eff && !interface_clock_prev_q) begin
            slave_read_strobe  <= mode_slave &&
                                  (rdy_s[0] == fifo_pin_polarity_q[PFM_POL_RD]);
            slave_write_strobe <= mode_slave &&
                                  (rdy_s[1] == fifo_pin_polarity_q[PFM_POL_WR]);
            wave_ready_in      <= {rdy_s[5:2], mode_slave ? 2'b00 : rdy_s[1:0]};
            wave_control_pin_o[5:3] <= wave_control_out[5:3];
            if (mode_slave) begin
                wave_control_pin_o[0] <= fifo_flags.prog[fadr_s];
                wave_control_pin_o[1] <= fifo_flags.full[fadr_s];
                wave_control_pin_o[2] <= fifo_flags.empty[fadr_s];
            end else begin
                wave_control_pin_o[2:0] <= wave_control_out[2:0];
            end
            wave_control_pin_oe <= (mode_slave || mode_wave) ? 6'h3F : 6'h00;
            fifo_data_hi_i      <= pd_s;
        end else if (!mode_slave) begin
            slave_read_strobe  <= 1'b0;
            slave_write_strobe <= 1'b0;
        end
    end

    // port e pin drivers
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            port_e_pin_o  <= '0;
            port_e_pin_oe <= '0;
        end else begin
            for (int i = 0; i < 8; i++) begin
                port_e_pin_o[i]  <= pe_out_q[i];
                port_e_pin_oe[i] <= pe_oe_q[i];
            end
            if (port_e_alt_select_q[PFM_PE_T0]) begin
                port_e_pin_o[PFM_PE_T0]  <= timer0_overflow;
                port_e_pin_oe[PFM_PE_T0] <= 1'b1;
            end
            if (port_e_alt_select_q[PFM_PE_T1]) begin
                port_e_pin_o[PFM_PE_T1]  <= timer1_overflow;
                port_e_pin_oe[PFM_PE_T1] <= 1'b1;
            end
            if (port_e_alt_select_q[PFM_PE_T2]) begin
                port_e_pin_o[PFM_PE_T2]  <= timer2_overflow;
                port_e_pin_oe[PFM_PE_T2] <= 1'b1;
            end
            if (port_e_alt_select_q[PFM_PE_SER0]) begin
                port_e_pin_o[PFM_PE_SER0]  <= (serial0_mode == 2'b00) ? serial0_data : 1'b1;
                port_e_pin_oe[PFM_PE_SER0] <= 1'b1;
            end
            if (port_e_alt_select_q[PFM_PE_SER1]) begin
                port_e_pin_o[PFM_PE_SER1]  <= (serial1_mode == 2'b00) ? serial1_data : 1'b1;
                port_e_pin_oe[PFM_PE_SER1] <= 1'b1;
            end
            if (port_e_alt_select_q[PFM_PE_IRQ6]) begin
                port_e_pin_oe[PFM_PE_IRQ6] <= 1'b0;
            end
            if (port_e_alt_select_q[PFM_PE_TIMER2_RELOAD_INPUT]) begin
                port_e_pin_oe[PFM_PE_TIMER2_RELOAD_INPUT] <= 1'b0;
            end
            if (port_e_alt_select_q[PFM_PE_ADDR8]) begin
                port_e_pin_o[PFM_PE_ADDR8]  <= wave_address_bit8;
                port_e_pin_oe[PFM_PE_ADDR8] <= 1'b1;
            end
        end
    end

    // port d pin drivers, upper data bus in word-wide mode
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            port_d_pin_o  <= '0;
            port_d_pin_oe <= '0;
        end else if (wide_bus) begin
            port_d_pin_o  <= fifo_data_hi_o;
            port_d_pin_oe <= fifo_data_hi_oe ? ALL1 : 8'h00;
        end else begin
            port_d_pin_o  <= pd_out_q;
            port_d_pin_oe <= pd_oe_q;
        end
    end

    // axi write channel, both address and data taken together
    logic [3:0] widx;
    assign widx = reg_index(s_axi_awaddr);
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_awready       <= 1'b0;
            s_axi_wready        <= 1'b0;
            s_axi_bvalid        <= 1'b0;
            s_axi_bresp         <= PFM_RESP_OKAY;
            port_e_alt_select_q <= PFM_RST_BYTE;
            interface_config_q  <= PFM_RST_BYTE;
            fifo_pin_polarity_q <= PFM_RST_BYTE;
            misc_ctrl_q         <= PFM_RST_BYTE;
            pe_out_q            <= PFM_RST_BYTE;
            pe_oe_q             <= PFM_RST_BYTE;
            pd_out_q            <= PFM_RST_BYTE;
            pd_oe_q             <= PFM_RST_BYTE;
        end else begin
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
            if (s_axi_awvalid && s_axi_wvalid && !s_axi_awready && !s_axi_bvalid) begin
                s_axi_awready <= 1'b1;
                s_axi_wready  <= 1'b1;
                s_axi_bvalid  <= 1'b1;
                s_axi_bresp   <= (widx == 4'(PFM_NREG)) ? PFM_RESP_SLVERR : PFM_RESP_OKAY;
                if (s_axi_wstrb[0] && widx != 4'(PFM_NREG)) begin
                    case (s_axi_awaddr[7:0])
                        PFM_ADDR_PORT_E_ALT: port_e_alt_select_q <= s_axi_wdata[7:0];
                        PFM_ADDR_IF_CONFIG:  interface_config_q  <= s_axi_wdata[7:0];
                        PFM_ADDR_PIN_POLAR:  fifo_pin_polarity_q <= s_axi_wdata[7:0];
                        PFM_ADDR_MISC_CTRL:  misc_ctrl_q         <= s_axi_wdata[7:0];
                        PFM_ADDR_PE_OUT:     pe_out_q            <= s_axi_wdata[7:0];
                        PFM_ADDR_PE_OE:      pe_oe_q             <= s_axi_wdata[7:0];
                        PFM_ADDR_PD_OUT:     pd_out_q            <= s_axi_wdata[7:0];
                        PFM_ADDR_PD_OE:      pd_oe_q             <= s_axi_wdata[7:0];
                        default: ;
                    endcase
                end
            end
        end
    end

    // axi read channel
    logic [31:0] rmux;
    always_comb begin
        rmux = 32'h0000_0000;
        case (s_axi_araddr[7:0])
            PFM_ADDR_PORT_E_ALT: rmux[7:0] = port_e_alt_select_q;
            PFM_ADDR_IF_CONFIG:  rmux[7:0] = interface_config_q;
            PFM_ADDR_PIN_POLAR:  rmux[7:0] = fifo_pin_polarity_q;
            PFM_ADDR_MISC_CTRL:  rmux[7:0] = misc_ctrl_q;
            PFM_ADDR_PE_OUT:     rmux[7:0] = pe_out_q;
            PFM_ADDR_PE_OE:      rmux[7:0] = pe_oe_q;
            PFM_ADDR_PD_OUT:     rmux[7:0] = pd_out_q;
            PFM_ADDR_PD_OE:      rmux[7:0] = pd_oe_q;
            PFM_ADDR_PIN_STATUS: rmux[27:0] = sync_q;
            default:             rmux = 32'h0000_0000;
        endcase
    end
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0000_0000;
            s_axi_rresp   <= PFM_RESP_OKAY;
        end else begin
            s_axi_arready <= 1'b0;
            if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
            if (s_axi_arvalid && !s_axi_arready && !s_axi_rvalid) begin
                s_axi_arready <= 1'b1;
                s_axi_rvalid  <= 1'b1;
                s_axi_rdata   <= (reg_index(s_axi_araddr) == 4'(PFM_NREG)) ? 32'h0000_0000 : rmux;
                s_axi_rresp   <= (reg_index(s_axi_araddr) == 4'(PFM_NREG)) ?
                                 PFM_RESP_SLVERR : PFM_RESP_OKAY;
            end
        end
    end

    // checks on the pin behaviour
    a_irq4_one_event: assert property (@(posedge aclk) disable iff (!aresetn)
        irq4_req |=> !irq4_req) else $error("irq4 request longer than one cycle");
    a_irq5_fall_edge: assert property (@(posedge aclk) disable iff (!aresetn)
        (prev_q[15] && !irq5_s) |=> irq5_req) else $error("irq5 falling edge missed");
    a_irq6_gated: assert property (@(posedge aclk) disable iff (!aresetn)
        irq6_req |-> $past(port_e_alt_select_q[PFM_PE_IRQ6])) else $error("irq6 not selected");
    a_reload_needs_en: assert property (@(posedge aclk) disable iff (!aresetn)
        timer2_reload |-> $past(misc_ctrl_q[PFM_MISC_T2_EXT])) else $error("reload w/o enable");
    a_t2_pulse_pin: assert property (@(posedge aclk) disable iff (!aresetn)
        port_e_alt_select_q[PFM_PE_T2] && $stable(port_e_alt_select_q) |=>
        port_e_pin_o[PFM_PE_T2] == $past(timer2_overflow)) else $error("t2 pulse wrong");
    a_ser1_idle_high: assert property (@(posedge aclk) disable iff (!aresetn)
        port_e_alt_select_q[PFM_PE_SER1] && serial1_mode != 2'b00 ##1
        port_e_alt_select_q[PFM_PE_SER1] |-> port_e_pin_o[PFM_PE_SER1])
        else $error("serial1 echo not high");
    a_flag_b_full: assert property (@(posedge aclk) disable iff (!aresetn)
        mode_slave && interface_clock_eff && !interface_clock_prev_q |=>
        wave_control_pin_o[1] == $past(fifo_flags.full[fadr_s])) else $error("flag b wrong");
    a_rd_strobe_mode: assert property (@(posedge aclk) disable iff (!aresetn)
        slave_read_strobe |-> $past(mode_slave, 1) || $past(mode_slave, 2))
        else $error("read strobe outside slave mode");
    a_portd_narrow: assert property (@(posedge aclk) disable iff (!aresetn)
        !wide_bus |=> port_d_pin_oe == $past(pd_oe_q)) else $error("port d hijacked");
    a_t1_count_sel: assert property (@(posedge aclk) disable iff (!aresetn)
        !misc_ctrl_q[PFM_MISC_T1_SEL] |=> !timer1_count) else $error("t1 counted unselected");
endmodule
`default_nettype wire

// *** pfm_pkg.sv ***
// constants, register map and carrier types for the port e and fifo pin mux
package pfm_pkg;
    // register byte addresses
    localparam logic [7:0] PFM_ADDR_PORT_E_ALT  = 8'h00;
    localparam logic [7:0] PFM_ADDR_IF_CONFIG   = 8'h04;
    localparam logic [7:0] PFM_ADDR_PIN_POLAR   = 8'h08;
    localparam logic [7:0] PFM_ADDR_MISC_CTRL   = 8'h0C;
    localparam logic [7:0] PFM_ADDR_PE_OUT      = 8'h10;
    localparam logic [7:0] PFM_ADDR_PE_OE       = 8'h14;
    localparam logic [7:0] PFM_ADDR_PD_OUT      = 8'h18;
    localparam logic [7:0] PFM_ADDR_PD_OE       = 8'h1C;
    localparam logic [7:0] PFM_ADDR_PIN_STATUS  = 8'h20;
    // number of registers, also the index given to an unmapped address
    localparam int PFM_NREG = 9;
    // reset values
    localparam logic [7:0] PFM_RST_BYTE = 8'h00;
    // interface_config fields
    localparam int PFM_IFC_INTERNAL = 7;
    localparam int PFM_IFC_RATE48   = 6;
    localparam int PFM_IFC_CLK_OE   = 5;
    localparam int PFM_IFC_INVERT   = 4;
    // interface modes
    typedef enum logic [1:0] {
        PFM_MODE_PORTS = 2'h0,
        PFM_MODE_RSVD  = 2'h1,
        PFM_MODE_WAVE  = 2'h2,
        PFM_MODE_SLAVE = 2'h3
    } pfm_mode_e;
    // fifo_pin_polarity fields
    localparam int PFM_POL_RD = 3;
    localparam int PFM_POL_WR = 2;
    // misc control fields
    localparam int PFM_MISC_T2_EXT   = 0;
    localparam int PFM_MISC_T1_SEL   = 1;
    localparam int PFM_MISC_WORDWIDE = 2;
    // port e alternate bit positions
    localparam int PFM_PE_T0    = 0;
    localparam int PFM_PE_T1    = 1;
    localparam int PFM_PE_T2    = 2;
    localparam int PFM_PE_SER0  = 3;
    localparam int PFM_PE_SER1  = 4;
    localparam int PFM_PE_IRQ6  = 5;
    localparam int PFM_PE_TIMER2_RELOAD_INPUT  = 6;
    localparam int PFM_PE_ADDR8 = 7;
    // interface clock generation
    localparam int PFM_CLK_MHZ    = 200;
    localparam int PFM_IFC_FAST   = 48;
    localparam int PFM_IFC_SLOW   = 30;
    localparam int PFM_ACC_BITS   = 16;
    localparam int PFM_STEP_FAST  = (2 * PFM_IFC_FAST * (1 << PFM_ACC_BITS)) / PFM_CLK_MHZ;
    localparam int PFM_STEP_SLOW  = (2 * PFM_IFC_SLOW * (1 << PFM_ACC_BITS)) / PFM_CLK_MHZ;
    // axi responses
    localparam logic [1:0] PFM_RESP_OKAY   = 2'h0;
    localparam logic [1:0] PFM_RESP_SLVERR = 2'h2;
    // fifo status flags, one bit per fifo
    typedef struct packed {
        logic [3:0] prog;
        logic [3:0] full;
        logic [3:0] empty;
    } pfm_flags_s;
endpackage

// *** pfm_far_end.sv ***
// far-end fifo master model: interface clock and strobe pins
`timescale 1ns/1ps
`default_nettype none
module pfm_far_end (
    input  wire logic       run,
    input  wire logic       rd,
    input  wire logic       wr,
    input  wire logic [1:0] pol,
    output logic            interface_clock,
    output logic [1:0]      rdy
);
    // clock toggles every 24 ns inside frames, stands low outside
    initial begin
        interface_clock = 1'b0;
        forever #24 interface_clock = run ? ~interface_clock : 1'b0;
    end
    // strobes shown at the programmed active level
    assign rdy = {wr ~^ pol[0], rd ~^ pol[1]};
endmodule
`default_nettype wire

// *** testbench.sv ***
// randomised self-checking bench for the pin mux
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import pfm_pkg::*;
    logic aclk = 0, aresetn = 0, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
    logic s_axi_arvalid = 0, s_axi_rready = 0, s_axi_awready, s_axi_wready, s_axi_bvalid;
    logic [31:0] s_axi_awaddr = 0, s_axi_wdata = 0, s_axi_araddr = 0, s_axi_rdata, v, d, w;
    logic [3:0] s_axi_wstrb = 4'hf, rdy_hi = 0;
    logic [1:0] s_axi_bresp, s_axi_rresp, fifo_address_pins = 0, serial0_mode = 0, r;
    logic [1:0] serial1_mode = 0, rdy01, pol = 0;
    logic [7:0] port_e_pin_i = 0, port_d_pin_i = 0, fifo_data_hi_o = 0, port_e_pin_o;
    logic [7:0] port_e_pin_oe, port_d_pin_o, port_d_pin_oe, fifo_data_hi_i;
    logic [5:0] wave_control_out = 0, wave_control_pin_o, wave_control_pin_oe, wave_ready_in;
    wire logic [5:0] wave_ready_pin = {rdy_hi, rdy01};
    logic s_axi_arready, s_axi_rvalid, interface_clock_i, interface_clock_o, interface_clock_oe;
    logic irq4_input = 0, irq5_input_n = 1, timer1_count_pin = 0, timer0_overflow = 0;
    logic timer1_overflow = 0, timer2_overflow = 0, serial0_data = 0, serial1_data = 0;
    logic wave_address_bit8 = 0, fifo_data_hi_oe = 0, slave_read_strobe, slave_write_strobe;
    logic interface_clock_edge, irq4_req, irq5_req, irq6_req, timer2_reload, timer1_count;
    logic run = 0, rd = 0, wr = 0;
    pfm_flags_s fifo_flags = '0;
    int failures = 0, checks = 0, n[8], e[8], ne = 0, nr = 0, nf = 0;
    wire logic [7:0] ev = {timer1_count, timer2_reload, irq6_req, irq5_req, irq4_req,
                           port_e_pin_o[2:0]};
    pfm_top i_dut (.*);
    pfm_far_end i_far (.run, .rd, .wr, .pol, .interface_clock(interface_clock_i), .rdy(rdy01));
    // clock and event tallies
    always #2.5 aclk = ~aclk;
    always @(posedge aclk) foreach (n[i]) n[i] += ev[i];
    always @(posedge aclk) ne += interface_clock_edge;
    always @(posedge interface_clock_i) nr++;
    always @(negedge interface_clock_i) nf++;
    // expected echo pin level for a serial port
    function automatic logic echo(logic [1:0] m, logic b);
        return (m == 2'b00) ? b : 1'b1;
    endfunction
    task automatic chk(string nm, logic [31:0] seen, logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            failures++;
            $display("wrong value %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    // axi writes and reads, one at a time, holding until taken
    task automatic axw(logic [7:0] a, logic [7:0] dd);
        s_axi_awaddr <= a; s_axi_wdata <= dd; s_axi_awvalid <= 1; s_axi_wvalid <= 1;
        s_axi_bready <= 1;
        do @(posedge aclk); while (!s_axi_awready);
        s_axi_awvalid <= 0; s_axi_wvalid <= 0;
        while (!s_axi_bvalid) @(posedge aclk);
        s_axi_bready <= 0;
        @(posedge aclk);
    endtask
    task automatic axr(logic [7:0] a);
        s_axi_araddr <= a; s_axi_arvalid <= 1; s_axi_rready <= 1;
        do @(posedge aclk); while (!s_axi_arready);
        s_axi_arvalid <= 0;
        while (!s_axi_rvalid) @(posedge aclk);
        d = s_axi_rdata; r = s_axi_rresp; s_axi_rready <= 0;
        @(posedge aclk);
    endtask
    task automatic end_of_test;
        if (failures == 0 && checks > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    // watchdog
    initial begin
        #20us;
        failures++;
        end_of_test;
    end
    // main sequence
    initial begin
        void'($urandom(32'h91b5));
        repeat (6) @(posedge aclk);
        aresetn <= 1;
        @(posedge aclk);
        chk("port e oe", port_e_pin_oe, 0);
        chk("port d oe", port_d_pin_oe, 0);
        chk("control oe", wave_control_pin_oe, 0);
        axr(PFM_ADDR_IF_CONFIG);
        chk("interface config", d, 0);
        axr(8'h40);
        chk("unmapped resp", r, PFM_RESP_SLVERR);
        axw(PFM_ADDR_PORT_E_ALT, 8'hff);
        axw(PFM_ADDR_MISC_CTRL, 8'h03);
        axw(PFM_ADDR_PD_OUT, 8'h5a);
        axw(PFM_ADDR_PD_OE, 8'hc3);
        repeat (40) begin
            v = $urandom;
            for (int i = 0; i < 3; i++) e[i] += v[5];
            e[3] += !irq4_input & v[0]; e[4] += irq5_input_n & !v[1];
            e[5] += !port_e_pin_i[5] & v[2]; e[6] += port_e_pin_i[6] & !v[3];
            e[7] += timer1_count_pin & !v[4];
            irq4_input <= v[0]; irq5_input_n <= v[1]; port_e_pin_i <= {1'b0, v[3:2], 5'h0};
            timer1_count_pin <= v[4];
            {timer0_overflow, timer1_overflow, timer2_overflow} <= {3{v[5]}};
            fifo_data_hi_o <= v[20:13];
            fifo_data_hi_oe <= v[21];
            serial0_mode <= v[7:6]; serial0_data <= v[8]; serial1_mode <= v[10:9];
            serial1_data <= v[11]; wave_address_bit8 <= v[12];
            @(posedge aclk);
            {timer0_overflow, timer1_overflow, timer2_overflow} <= 3'h0;
            repeat (4) @(posedge aclk);
            chk("addr bit8", port_e_pin_o[7], wave_address_bit8);
            chk("serial0 echo", port_e_pin_o[3], echo(serial0_mode, serial0_data));
            chk("serial1 echo", port_e_pin_o[4], echo(serial1_mode, serial1_data));
            chk("port e oe", port_e_pin_oe, 8'h9f);
            chk("port d narrow", {port_d_pin_oe, port_d_pin_o}, 16'hc35a);
        end
        repeat (8) @(posedge aclk);
        foreach (n[i]) chk("event count", n[i], e[i]);
        axw(PFM_ADDR_IF_CONFIG, 8'h03);
        axw(PFM_ADDR_MISC_CTRL, 8'h07);
        repeat (3) begin
            v = $urandom;
            axw(PFM_ADDR_PIN_POLAR, {4'h0, v[1:0], 2'b00});
            w = $urandom;
            port_d_pin_i <= w[7:0];
            wave_control_out <= w[13:8];
            fifo_data_hi_o <= w[21:14];
            fifo_data_hi_oe <= w[22];
            pol <= v[1:0]; rd <= v[2]; wr <= v[3]; fifo_address_pins <= v[5:4];
            fifo_flags <= v[17:6]; rdy_hi <= v[21:18]; nr = 0; ne = 0; run <= 1;
            repeat (60) @(posedge aclk);
            run <= 0;
            repeat (12) @(posedge aclk);
            chk("flags", wave_control_pin_o[2:0], {fifo_flags.empty[v[5:4]],
                fifo_flags.full[v[5:4]], fifo_flags.prog[v[5:4]]});
            chk("read strobe", slave_read_strobe, rd);
            chk("write strobe", slave_write_strobe, wr);
            chk("ready pins", wave_ready_in, {rdy_hi, 2'b00});
            chk("clock edges", ne, nr);
            chk("control pins", {wave_control_pin_oe, wave_control_pin_o[5:3]},
                {6'h3f, w[13:11]});
            chk("port d in", fifo_data_hi_i, w[7:0]);
            chk("port d wide", {port_d_pin_oe, port_d_pin_o}, {{8{w[22]}}, w[21:14]});
        end
        // wave mode: control and ready pins back to the engine
        axw(PFM_ADDR_IF_CONFIG, 8'h02);
        w = $urandom;
        wave_control_out <= w[5:0];
        rd <= 1;
        wr <= 1;
        pol <= 2'b11;
        run <= 1;
        repeat (60) @(posedge aclk);
        run <= 0;
        repeat (12) @(posedge aclk);
        chk("wave control", wave_control_pin_o, w[5:0]);
        chk("wave ready", wave_ready_in, {rdy_hi, 2'b11});
        chk("strobes off", {slave_read_strobe, slave_write_strobe}, 0);
        chk("port d wave", port_d_pin_o, fifo_data_hi_o);
        // inverted external clock: edges follow falling pin edges
        axw(PFM_ADDR_IF_CONFIG, 8'h12);
        repeat (4) @(posedge aclk);
        chk("clock out inverted", interface_clock_o, 1);
        chk("clock out off", interface_clock_oe, 0);
        ne = 0;
        nf = 0;
        run <= 1;
        repeat (60) @(posedge aclk);
        run <= 0;
        repeat (12) @(posedge aclk);
        chk("inverted edges", ne, nf);
        // internal clock at both rates, driven out
        axw(PFM_ADDR_IF_CONFIG, 8'he2);
        ne = 0;
        repeat (200) @(posedge aclk);
        chk("clock out on", interface_clock_oe, 1);
        chk("fast clock edges", ne >= 47 && ne <= 49, 1);
        axw(PFM_ADDR_IF_CONFIG, 8'ha2);
        ne = 0;
        repeat (200) @(posedge aclk);
        chk("slow clock edges", ne >= 29 && ne <= 31, 1);
        end_of_test;
    end
endmodule
`default_nettype wire
